/* File: design/pdtx_pkg.sv */
// Package with register map, field positions and encodings of the transmit policy block.
package pdtx_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] PDTX_OFS_POLICY = 16'h1a00;
  localparam logic [15:0] PDTX_OFS_CMD    = 16'h1a04;
  localparam logic [15:0] PDTX_OFS_PARAM  = 16'h1a08;
  localparam logic [15:0] PDTX_OFS_STAT   = 16'h1a0c;
  // ----------------------------------------------------------------
  // Policy control fields
  // ----------------------------------------------------------------
  localparam int          PDTX_B_RETRY_BUSY = 6;
  localparam int          PDTX_B_KEEP_NONPR = 5;
  localparam int          PDTX_B_NO_SR_EXMT = 4;
  localparam int          PDTX_B_HOLD_QUIET = 3;
  localparam int          PDTX_B_AUTO_REPLY = 2;
  localparam int          PDTX_B_FIFO_MODE  = 1;
  localparam int          PDTX_B_RAW_PROC   = 0;
  localparam logic [6:0]  PDTX_POLICY_RST   = 7'h00;
  // ----------------------------------------------------------------
  // Command, parameter and status fields
  // ----------------------------------------------------------------
  localparam int          PDTX_B_GO         = 0;
  localparam int          PDTX_B_CANCEL     = 1;
  localparam int          PDTX_F_SOP_LO     = 4;
  localparam int          PDTX_B_IS_RESET   = 7;
  localparam int          PDTX_F_LIMIT_LO   = 4;
  localparam logic [2:0]  PDTX_LIMIT_RST    = 3'h0;
  localparam int          PDTX_B_ACTIVE     = 0;
  localparam int          PDTX_B_ABORTED    = 1;
  localparam int          PDTX_B_FAILED     = 2;
  localparam int          PDTX_B_SENT       = 3;
  // ----------------------------------------------------------------
  // Start-of-packet type codes and controller state encoding
  // ----------------------------------------------------------------
  localparam logic [2:0]  PDTX_SOP          = 3'h0;
  localparam logic [2:0]  PDTX_SOP_P        = 3'h1;
  localparam logic [2:0]  PDTX_SOP_PP       = 3'h2;
  localparam logic [2:0]  PDTX_SOP_P_DBG    = 3'h3;
  localparam logic [2:0]  PDTX_SOP_PP_DBG   = 3'h4;
  typedef enum logic [1:0] {PDTX_IDLE, PDTX_ATTEMPT, PDTX_SEND} pdtx_state_e;
endpackage : pdtx_pkg

/* File: design/pdtx_policy.sv */
// Transmit abort, retry and auto-reply policy controller with an APB register slave.
// Functional notes
// (RL1) With no busy option set, a busy line aborts the packet and all retries.
// (RL2) Retry-on-busy retries up to the limit, then reports send failed.
// (RL3) Received hard reset or software cancel always aborts the pending packet.
// (RL4) Cable reset aborts only when detection enabled and pending type is non-primary.
// (RL5) Good non-ping non-GoodCRC packet aborts on matching type or primary over non-primary.
// (RL6) Keep-nonprimary bit stops primary packets aborting a non-primary packet.
// (RL7) In auto mode busy line never drops soft-reset GoodCRC unless exemption disabled.
// (RL8) With exemption disabled, hold-until-quiet also applies to soft-reset GoodCRC.
// (RL9) Hold-until-quiet keeps the packet until the line is idle, then sends.
// (RL10) Hold-until-quiet takes precedence over retry-on-busy.
// (RL11) Auto-reply bit enables hardware GoodCRC and error count replies.
// (RL12) Without auto-reply there are no hardware retries; limit ignored.
// (RL13) Queue mode bit selects buffer or FIFO write side.
// (RL14) Processing bit selects automatic or raw data processing.
// (RL15) Retry limit is three bits; zero disables hardware retries.
// (RL16) Hard and cable reset transmissions are never retried.
// (RL17) Any abort stops sending, cancels retries, sets aborted, returns idle.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
module pdtx_policy
  import pdtx_pkg::*;
(
  input  wire logic        pclk,          // Bus and MAC clock.
  input  wire logic        presetn,       // Asynchronous reset, active low.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB access phase.
  input  wire logic        pwrite,        // APB direction.
  input  wire logic [15:0] paddr,         // APB byte address.
  input  wire logic [31:0] pwdata,        // APB write data.
  output logic             pready,        // APB ready.
  output logic      [31:0] prdata,        // APB read data.
  output logic             pslverr,       // APB error on unmapped address.
  input  wire logic        line_busy,     // Line activity from the receiver.
  input  wire logic        phy_done,      // Pulse: attempt finished.
  input  wire logic        phy_ok,        // With phy_done: packet acknowledged.
  input  wire logic        hr_rx,         // Pulse: hard reset received.
  input  wire logic        cr_rx,         // Pulse: cable reset received.
  input  wire logic        cr_det_en,     // Cable reset detection enabled.
  input  wire logic        rx_good,       // Pulse: good non-duplicate packet.
  input  wire logic        rx_ping_gcrc,  // With rx_good: packet is Ping or GoodCRC.
  input  wire logic  [2:0] rx_sop,        // With rx_good: received packet type.
  input  wire logic        ack_req,       // Pulse: received packet needs GoodCRC.
  input  wire logic        ack_for_sr,    // With ack_req: packet was a soft reset.
  input  wire logic        bist_req,      // Pulse: error count reply due.
  output logic             phy_send,      // Pulse: start sending the packet.
  output logic             phy_halt,      // Pulse: stop the packet being sent.
  output logic             ack_send,      // Pulse: send a GoodCRC now.
  output logic             bist_send,     // Pulse: send an error count reply.
  output logic             fifo_mode,     // Queue write side in FIFO order.
  output logic             raw_mode       // Raw data processing selected.
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  pdtx_state_e st_r, st_nxt;
  logic [6:0]  pol_r, pol_nxt;
  logic [2:0]  lim_r, lim_nxt, sop_r, sop_nxt, cnt_r, cnt_nxt;
  logic        rst_pkt_r, rst_pkt_nxt;
  logic        abt_r, abt_nxt, fail_r, fail_nxt, sent_r, sent_nxt;
  logic        ackp_r, ackp_nxt, acksr_r, acksr_nxt;
  logic        rdy_r, rdy_nxt, err_r, err_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        send_r, send_nxt, halt_r, halt_nxt, acks_r, acks_nxt, bist_r, bist_nxt;
  logic        wr_en, hit, go_w, cancel_w, abort_now, retry_ok, may_retry;
  logic        cr_abort, rx_abort, busy_fail;

  assign pready    = rdy_r;
  assign prdata    = rd_r;
  assign pslverr   = err_r;
  assign phy_send  = send_r;
  assign phy_halt  = halt_r;
  assign ack_send  = acks_r;
  assign bist_send = bist_r;
  assign fifo_mode = pol_r[PDTX_B_FIFO_MODE]; // RL13
  assign raw_mode  = pol_r[PDTX_B_RAW_PROC];  // RL14

  // ----------------------------------------------------------------
  // Abort and retry decisions
  // ----------------------------------------------------------------
  // A write lands only at the edge where pready is seen high.
  assign wr_en    = psel & penable & rdy_r & pwrite & ~err_r;
  assign go_w     = wr_en & (paddr == PDTX_OFS_CMD) & pwdata[PDTX_B_GO];
  assign cancel_w = wr_en & (paddr == PDTX_OFS_CMD) & pwdata[PDTX_B_CANCEL];
  assign cr_abort = cr_rx & cr_det_en & (sop_r inside {PDTX_SOP_P, PDTX_SOP_PP,
                    PDTX_SOP_P_DBG, PDTX_SOP_PP_DBG}); // RL4
  assign rx_abort = rx_good & ~rx_ping_gcrc & ((rx_sop == sop_r) |
                    ((rx_sop == PDTX_SOP) & (sop_r != PDTX_SOP) &
                     ~pol_r[PDTX_B_KEEP_NONPR])); // RL5 RL6
  assign abort_now = hr_rx | cancel_w | cr_abort | rx_abort; // RL3
  // Hardware retries need auto-reply, a nonzero limit and an ordinary packet.
  assign may_retry = pol_r[PDTX_B_AUTO_REPLY] & (lim_r != 3'h0) & ~rst_pkt_r; // RL12 RL15 RL16
  assign retry_ok  = may_retry & (cnt_r < lim_r); // RL2
  assign busy_fail = pol_r[PDTX_B_RETRY_BUSY] & ~pol_r[PDTX_B_HOLD_QUIET];  // RL10

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    abt_nxt  = abt_r;
    fail_nxt = fail_r;
    sent_nxt = sent_r;
    send_nxt = 1'b0;
    halt_nxt = 1'b0;
    if (wr_en && paddr == PDTX_OFS_STAT) begin
      abt_nxt  = abt_r & ~pwdata[PDTX_B_ABORTED];
      fail_nxt = fail_r & ~pwdata[PDTX_B_FAILED];
      sent_nxt = sent_r & ~pwdata[PDTX_B_SENT];
    end
    case (st_r)
      PDTX_IDLE: begin
        if (go_w && !cancel_w) begin
          st_nxt   = PDTX_ATTEMPT;
          cnt_nxt  = 3'h0;
          abt_nxt  = 1'b0;
          fail_nxt = 1'b0;
          sent_nxt = 1'b0;
        end
      end
      PDTX_ATTEMPT: begin
        if (abort_now) begin
          st_nxt  = PDTX_IDLE; // RL17
          abt_nxt = 1'b1;
        end else if (!line_busy) begin
          st_nxt   = PDTX_SEND; // RL9
          send_nxt = 1'b1;
        end else if (pol_r[PDTX_B_HOLD_QUIET]) begin
          st_nxt = PDTX_ATTEMPT; // RL9 RL10
        end else if (busy_fail) begin
          if (retry_ok) begin
            cnt_nxt = cnt_r + 3'h1; // RL2
          end else begin
            st_nxt   = PDTX_IDLE;
            fail_nxt = 1'b1;
          end
        end else begin
          st_nxt  = PDTX_IDLE; // RL1
          abt_nxt = 1'b1;
        end
      end
      PDTX_SEND: begin
        if (abort_now) begin
          st_nxt   = PDTX_IDLE; // RL17
          abt_nxt  = 1'b1;
          halt_nxt = 1'b1;
        end else if (phy_done && phy_ok) begin
          st_nxt   = PDTX_IDLE;
          sent_nxt = 1'b1;
        end else if (phy_done && retry_ok) begin
          st_nxt  = PDTX_ATTEMPT;
          cnt_nxt = cnt_r + 3'h1;
        end else if (phy_done) begin
          st_nxt   = PDTX_IDLE; // RL12 RL16
          fail_nxt = 1'b1;
        end
      end
      default: st_nxt = PDTX_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Automatic replies
  // ----------------------------------------------------------------
  // A request seen while a GoodCRC is held back by a busy line replaces it.
  always_comb begin
    ackp_nxt  = ackp_r;
    acksr_nxt = acksr_r;
    acks_nxt  = 1'b0;
    bist_nxt  = bist_req & pol_r[PDTX_B_AUTO_REPLY]; // RL11
    if (ackp_r) begin
      if (!line_busy || (acksr_r && !pol_r[PDTX_B_NO_SR_EXMT])) begin
        acks_nxt = 1'b1; // RL7
        ackp_nxt = 1'b0;
      end else if (!pol_r[PDTX_B_HOLD_QUIET]) begin
        ackp_nxt = 1'b0; // RL8
      end
    end
    if (ack_req && pol_r[PDTX_B_AUTO_REPLY]) begin
      ackp_nxt  = 1'b1; // RL11
      acksr_nxt = ack_for_sr;
    end
    if (!pol_r[PDTX_B_AUTO_REPLY]) begin
      ackp_nxt = 1'b0;
      acks_nxt = 1'b0; // RL11
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Every access takes one wait state, so read data always comes from a flop.
  always_comb begin
    hit     = paddr inside {PDTX_OFS_POLICY, PDTX_OFS_CMD, PDTX_OFS_PARAM, PDTX_OFS_STAT};
    rdy_nxt = psel & penable & ~rdy_r;
    err_nxt = psel & penable & ~rdy_r & ~hit;
    rd_nxt  = rd_r;
    pol_nxt = pol_r;
    lim_nxt = lim_r;
    sop_nxt = sop_r;
    rst_pkt_nxt = rst_pkt_r;
    if (psel && penable && !rdy_r) begin
      rd_nxt = 32'h0000_0000;
      case (paddr)
        PDTX_OFS_POLICY: rd_nxt[6:0] = pol_r;
        PDTX_OFS_CMD: begin
          rd_nxt[PDTX_F_SOP_LO +: 3] = sop_r;
          rd_nxt[PDTX_B_IS_RESET]    = rst_pkt_r;
        end
        PDTX_OFS_PARAM: rd_nxt[PDTX_F_LIMIT_LO +: 3] = lim_r;
        PDTX_OFS_STAT: begin
          rd_nxt[PDTX_B_ACTIVE]       = (st_r != PDTX_IDLE);
          rd_nxt[PDTX_B_ABORTED]      = abt_r;
          rd_nxt[PDTX_B_FAILED]       = fail_r;
          rd_nxt[PDTX_B_SENT]         = sent_r;
          rd_nxt[PDTX_F_LIMIT_LO +: 3] = cnt_r;
        end
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_en && paddr == PDTX_OFS_POLICY) begin
      pol_nxt = pwdata[6:0];
    end
    if (wr_en && paddr == PDTX_OFS_PARAM) begin
      lim_nxt = pwdata[PDTX_F_LIMIT_LO +: 3];
    end
    if (go_w && !cancel_w && st_r == PDTX_IDLE) begin
      sop_nxt     = pwdata[PDTX_F_SOP_LO +: 3];
      rst_pkt_nxt = pwdata[PDTX_B_IS_RESET];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= PDTX_IDLE;
      pol_r     <= PDTX_POLICY_RST;
      lim_r     <= PDTX_LIMIT_RST;
      sop_r     <= PDTX_SOP;
      cnt_r     <= 3'h0;
      rst_pkt_r <= 1'b0;
      abt_r     <= 1'b0;
      fail_r    <= 1'b0;
      sent_r    <= 1'b0;
      ackp_r    <= 1'b0;
      acksr_r   <= 1'b0;
      rdy_r     <= 1'b0;
      err_r     <= 1'b0;
      rd_r      <= 32'h0000_0000;
      send_r    <= 1'b0;
      halt_r    <= 1'b0;
      acks_r    <= 1'b0;
      bist_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      pol_r     <= pol_nxt;
      lim_r     <= lim_nxt;
      sop_r     <= sop_nxt;
      cnt_r     <= cnt_nxt;
      rst_pkt_r <= rst_pkt_nxt;
      abt_r     <= abt_nxt;
      fail_r    <= fail_nxt;
      sent_r    <= sent_nxt;
      ackp_r    <= ackp_nxt;
      acksr_r   <= acksr_nxt;
      rdy_r     <= rdy_nxt;
      err_r     <= err_nxt;
      rd_r      <= rd_nxt;
      send_r    <= send_nxt;
      halt_r    <= halt_nxt;
      acks_r    <= acks_nxt;
      bist_r    <= bist_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_hr_aborts: assert property (@(posedge pclk) disable iff (!presetn) // RL3
    (st_r != PDTX_IDLE) && hr_rx |=> (st_r == PDTX_IDLE) && abt_r)
    else $error("hard reset did not abort the packet");
  a_busy_abort: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    (st_r == PDTX_ATTEMPT) && line_busy && !abort_now && !pol_r[PDTX_B_RETRY_BUSY]
    && !pol_r[PDTX_B_HOLD_QUIET] |=> (st_r == PDTX_IDLE) && abt_r && !fail_r)
    else $error("busy line did not abort the packet");
  a_hold_quiet: assert property (@(posedge pclk) disable iff (!presetn) // RL9 RL10
    (st_r == PDTX_ATTEMPT) && line_busy && !abort_now && pol_r[PDTX_B_HOLD_QUIET]
    |=> (st_r == PDTX_ATTEMPT) && !abt_r && !fail_r && $stable(cnt_r))
    else $error("held packet left the wait");
  a_cable_abort: assert property (@(posedge pclk) disable iff (!presetn) // RL4
    (st_r == PDTX_SEND) && cr_rx && cr_det_en && (sop_r == PDTX_SOP_PP)
    |=> (st_r == PDTX_IDLE) && abt_r && phy_halt ##1 !phy_halt)
    else $error("cable reset did not abort");
  a_sop_keep: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    (st_r == PDTX_SEND) && rx_good && (rx_sop == PDTX_SOP) && (sop_r != PDTX_SOP)
    && pol_r[PDTX_B_KEEP_NONPR] && !hr_rx && !cancel_w && !cr_abort && !phy_done
    |=> (st_r == PDTX_SEND) && !phy_halt)
    else $error("primary packet aborted a kept packet");
  a_sr_exempt: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    ackp_r && acksr_r && line_busy && !pol_r[PDTX_B_NO_SR_EXMT] |=> ack_send)
    else $error("soft reset GoodCRC held back by busy line");
  a_no_auto: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    !pol_r[PDTX_B_AUTO_REPLY] |=> !bist_send && !ack_send)
    else $error("automatic reply while auto-reply is off");
  a_manual_fail: assert property (@(posedge pclk) disable iff (!presetn) // RL12 RL16
    (st_r == PDTX_SEND) && phy_done && !phy_ok && !abort_now
    && (!pol_r[PDTX_B_AUTO_REPLY] || rst_pkt_r) |=> (st_r == PDTX_IDLE) && fail_r)
    else $error("hardware retried a packet it must not retry");
  a_retry_bound: assert property (@(posedge pclk) disable iff (!presetn) // RL2 RL15
    (st_r != PDTX_IDLE) && (cnt_r != 3'h0) && $changed(cnt_r) |-> $past(cnt_r) < $past(lim_r))
    else $error("retry count passed the limit");
endmodule : pdtx_policy

/* File: sim/pdtx_far_end.sv */
// Far-end model: cable line activity and the PHY that answers transmit attempts.
`timescale 1ns/1ns
module pdtx_far_end (
  input  wire logic       pclk,      // Clock.
  input  wire logic       presetn,   // Reset, active low.
  input  wire logic       arm,       // Pulse: load the busy time.
  input  wire logic [7:0] busy_len,  // Busy cycles after arm.
  input  wire logic       nack,      // Refuse every attempt.
  input  wire logic [7:0] dly,       // Cycles from start to done.
  input  wire logic       phy_send,  // Attempt start.
  input  wire logic       phy_halt,  // Attempt stop.
  output logic            line_busy, // Line activity.
  output logic            phy_done,  // Attempt finished.
  output logic            phy_ok     // Attempt acknowledged.
);
  logic [7:0] busy_r;
  logic [7:0] cnt_r;
  assign line_busy = busy_r != 8'h00;
  // The ok line toggles outside done so a stale value never looks meaningful.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r   <= 8'h00;
      cnt_r    <= 8'h00;
      phy_done <= 1'b0;
      phy_ok   <= 1'b0;
    end else begin
      busy_r   <= arm ? busy_len : busy_r - {7'h00, line_busy};
      cnt_r    <= phy_halt ? 8'h00 : (phy_send ? dly : cnt_r - {7'h00, cnt_r != 8'h00});
      phy_done <= cnt_r == 8'h01 && !phy_halt;
      phy_ok   <= (cnt_r == 8'h01) ? !nack : ~phy_ok;
    end
  end
endmodule // pdtx_far_end

/* File: sim/tb_pdtx_policy.sv */
// Self-checking bench for the transmit policy block.
`timescale 1ns/1ns
module tb_pdtx_policy;
  import pdtx_pkg::*;
  typedef struct {
    logic [7:0] pol;
    logic [2:0] lim;
    logic [7:0] bz;
    logic       nk;
    logic       rp;
    logic [3:0] st;
    logic [3:0] ns;
  } pdtx_tb_row_s;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, arm = 0, nack = 0;
  logic hr_rx = 0, cr_rx = 0, cr_det_en = 0, rx_good = 0, rx_ping_gcrc = 0;
  logic ack_req = 0, ack_for_sr = 0, bist_req = 0, err;
  logic pready, pslverr, line_busy, phy_done, phy_ok, phy_send, phy_halt;
  logic ack_send, bist_send, fifo_mode, raw_mode;
  logic [2:0]  rx_sop = '0;
  logic [7:0]  busy_len = '0, dly = 8'h03;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  int n_mismatch = 0, comparisons = 0, n_send = 0, n_halt = 0, n_ack = 0, n_bist = 0;
  pdtx_tb_row_s rows [9] = '{
    '{8'h00, 3'h0, 8'hff, 0, 0, 4'h2, 4'h0}, '{8'h44, 3'h2, 8'hff, 0, 0, 4'h4, 4'h0},
    '{8'h4c, 3'h2, 8'h0a, 0, 0, 4'h8, 4'h1}, '{8'h04, 3'h0, 8'h00, 1, 0, 4'h4, 4'h1},
    '{8'h00, 3'h3, 8'h00, 1, 0, 4'h4, 4'h1}, '{8'h04, 3'h2, 8'h00, 1, 0, 4'h4, 4'h3},
    '{8'h04, 3'h3, 8'h00, 1, 1, 4'h4, 4'h1}, '{8'h03, 3'h0, 8'h00, 0, 0, 4'h8, 4'h1},
    '{8'h08, 3'h0, 8'h0a, 0, 0, 4'h8, 4'h1}};
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    if (phy_send === 1'b1) n_send <= n_send + 1;
    if (phy_halt === 1'b1) n_halt <= n_halt + 1;
    if (ack_send === 1'b1) n_ack <= n_ack + 1;
    if (bist_send === 1'b1) n_bist <= n_bist + 1;
  end
  pdtx_policy i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .line_busy(line_busy), .phy_done(phy_done), .phy_ok(phy_ok),
    .hr_rx(hr_rx), .cr_rx(cr_rx), .cr_det_en(cr_det_en), .rx_good(rx_good),
    .rx_ping_gcrc(rx_ping_gcrc), .rx_sop(rx_sop), .ack_req(ack_req),
    .ack_for_sr(ack_for_sr), .bist_req(bist_req), .phy_send(phy_send),
    .phy_halt(phy_halt), .ack_send(ack_send), .bist_send(bist_send),
    .fifo_mode(fifo_mode), .raw_mode(raw_mode));
  pdtx_far_end i_far (.pclk(pclk), .presetn(presetn), .arm(arm), .busy_len(busy_len),
    .nack(nack), .dly(dly), .phy_send(phy_send), .phy_halt(phy_halt),
    .line_busy(line_busy), .phy_done(phy_done), .phy_ok(phy_ok));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Entered just after an edge; leaves one idle cycle so calls can follow at once.
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      print_verdict();
    end
    @(posedge pclk);
  endtask
  task automatic abrt(input logic [2:0] sop, input logic [2:0] e, input logic [2:0] rs,
                      input logic pg, input logic kp, input logic cd, input logic ex);
    int h;
    apb(1'b1, PDTX_OFS_POLICY, {26'h0, kp, 5'h04});
    cr_det_en <= cd;
    rx_sop <= rs;
    rx_ping_gcrc <= pg;
    dly <= 8'h28;
    apb(1'b1, PDTX_OFS_CMD, {24'h0, 1'b0, sop, 4'h1});
    wt(3);
    h = n_halt;
    {hr_rx, cr_rx, rx_good} <= e;
    @(posedge pclk) {hr_rx, cr_rx, rx_good} <= 3'h0;
    wt(3);
    apb(1'b0, PDTX_OFS_STAT, 32'h0);
    chk("aborted", rd[1], ex);
    chk("halts", n_halt - h, ex);
    apb(1'b1, PDTX_OFS_CMD, 32'h0000_0002);
    wt(2);
    apb(1'b0, PDTX_OFS_STAT, 32'h0);
    chk("cancel", rd[1:0], 2'b10);
  endtask
  task automatic ackc(input logic [7:0] pol, input logic [7:0] bz, input logic sr,
                      input logic b, input int ex);
    int a;
    apb(1'b1, PDTX_OFS_POLICY, {24'h0, pol});
    busy_len <= bz;
    arm <= 1'b1;
    @(posedge pclk) arm <= 1'b0;
    a = b ? n_bist : n_ack;
    ack_for_sr <= sr;
    ack_req <= !b;
    bist_req <= b;
    @(posedge pclk) ack_req <= 1'b0;
    bist_req <= 1'b0;
    wt(16);
    chk("replies", (b ? n_bist : n_ack) - a, ex);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int k, j, s0;
    wt(10);
    chk("outputs in reset", {pready, pslverr, phy_send, phy_halt, ack_send, bist_send,
        fifo_mode, raw_mode}, 0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, PDTX_OFS_POLICY, 32'h0);
    chk("policy reset", rd, 32'h0);
    apb(1'b0, PDTX_OFS_PARAM, 32'h0);
    chk("limit reset", rd, 32'h0);
    apb(1'b1, PDTX_OFS_POLICY, 32'h0000_00ff);
    apb(1'b0, PDTX_OFS_POLICY, 32'h0);
    chk("policy rw", rd, 32'h0000_007f);
    apb(1'b0, 16'h1a10, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h0000_0001);
    chk("unmapped data", rd, 32'h0);
    for (k = 0; k < 9; k++) begin
      apb(1'b1, PDTX_OFS_POLICY, {24'h0, rows[k].pol});
      apb(1'b1, PDTX_OFS_PARAM, {25'h0, rows[k].lim, 4'h0});
      nack <= rows[k].nk;
      busy_len <= rows[k].bz;
      dly <= 8'h03;
      arm <= 1'b1;
      @(posedge pclk) arm <= 1'b0;
      s0 = n_send;
      apb(1'b1, PDTX_OFS_CMD, {24'h0, rows[k].rp, 7'h01});
      for (j = 0; j < 300; j++) begin
        apb(1'b0, PDTX_OFS_STAT, 32'h0);
        if (rd[0] === 1'b0) break;
      end
      if (j == 300) begin
        n_mismatch++;
        print_verdict();
      end
      chk("status", rd[3:0], rows[k].st);
      chk("sends", n_send - s0, rows[k].ns);
      chk("modes", {fifo_mode, raw_mode}, rows[k].pol[1:0]);
    end
    nack <= 1'b0;
    abrt(3'h0, 3'b100, 3'h0, 0, 0, 0, 1);
    abrt(3'h1, 3'b010, 3'h0, 0, 0, 1, 1);
    abrt(3'h4, 3'b010, 3'h0, 0, 0, 1, 1);
    abrt(3'h0, 3'b010, 3'h0, 0, 0, 1, 0);
    abrt(3'h2, 3'b010, 3'h0, 0, 0, 0, 0);
    abrt(3'h2, 3'b010, 3'h0, 0, 0, 1, 1);
    abrt(3'h1, 3'b001, 3'h1, 0, 0, 0, 1);
    abrt(3'h1, 3'b001, 3'h0, 0, 0, 0, 1);
    abrt(3'h1, 3'b001, 3'h2, 0, 0, 0, 0);
    abrt(3'h1, 3'b001, 3'h1, 1, 0, 0, 0);
    abrt(3'h1, 3'b001, 3'h0, 0, 1, 0, 0);
    abrt(3'h2, 3'b001, 3'h2, 0, 1, 0, 1);
    ackc(8'h00, 8'h00, 0, 0, 0);
    ackc(8'h04, 8'h00, 0, 0, 1);
    ackc(8'h04, 8'h08, 1, 0, 1);
    ackc(8'h04, 8'h08, 0, 0, 0);
    ackc(8'h14, 8'h08, 1, 0, 0);
    ackc(8'h1c, 8'h08, 1, 0, 1);
    ackc(8'h04, 8'h00, 0, 1, 1);
    ackc(8'h00, 8'h00, 0, 1, 0);
    apb(1'b1, PDTX_OFS_POLICY, 32'h0000_0043);
    presetn <= 1'b0;
    wt(2);
    chk("modes in reset", {fifo_mode, raw_mode}, 2'b00);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, PDTX_OFS_POLICY, 32'h0);
    chk("policy after reset", rd, 32'h0);
    print_verdict();
  end
  initial begin
    wt(100000);
    n_mismatch++;
    print_verdict();
  end
endmodule // tb_pdtx_policy
